/* shared/xbus_irq_map.svh */
// register offsets, field positions, reset values and trap vector constants
`ifndef XBUS_IRQ_MAP_SVH
`define XBUS_IRQ_MAP_SVH

// =====================================================================
// register byte addresses
`define XIRQ_SEL_BASE   4'h0
`define XIRQ_TFR_OFS    8'h10
`define XIRQ_STAT_OFS   8'h14
`define XIRQ_MASK_OFS   8'h18

// =====================================================================
// reset values
`define XIRQ_SEL_RST    16'h0000
`define XIRQ_PEND_RST   5'h01

// =====================================================================
// trap flag register bit positions
`define TFR_NMI         15
`define TFR_STACK_OVER_FLAG       14
`define TFR_STACK_UNDER_FLAG       13
`define TFR_UNDOP       7
`define TFR_MAC         6
`define TFR_PROT        3
`define TFR_BADOP       2
`define TFR_BADFETCH    1
`define TFR_BADBUS      0

// =====================================================================
// trap vectors, numbers and priority levels
`define VEC_RESET       24'h00_0000
`define VEC_NMI         24'h00_0008
`define VEC_STACK_OVER_FLAG       24'h00_0010
`define VEC_STACK_UNDER_FLAG       24'h00_0018
`define VEC_CLASS_B     24'h00_0028
`define NUM_RESET       8'h00
`define NUM_NMI         8'h02
`define NUM_STACK_OVER_FLAG       8'h04
`define NUM_STACK_UNDER_FLAG       8'h06
`define NUM_CLASS_B     8'h0A
`define LVL_NONE        2'h0
`define LVL_CLASS_B     2'h1
`define LVL_CLASS_A     2'h2
`define LVL_RESET       2'h3
`define ILVL_MAX        4'hF
`define ILVL_NONE       4'h0

`endif

/* shared/xbus_irq_pkg.sv */
// types shared by the interrupt multiplexer and trap vector logic
package xbus_irq_pkg;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;
   typedef struct packed {
      logic [7:0] enable;
      logic [7:0] flag;
   } sel_reg_t;
   typedef struct packed {
      logic first_can_controller;
      logic second_can_controller;
      logic i2c_rx;
      logic i2c_tx;
      logic i2c_err;
      logic sync_rx;
      logic sync_tx;
      logic sync_err;
      logic async_rx;
      logic async_tx;
      logic async_tbuf;
      logic async_err;
      logic pll_unlock;
      logic second_pwm_unit;
   } xsrc_t;
   typedef struct packed {
      logic sw_reset;
      logic wdt_overflow;
      logic nmi;
      logic stack_over;
      logic stack_under;
      logic undefined_opcode;
      logic mac_interruption;
      logic protected_fault;
      logic bad_operand;
      logic bad_fetch;
      logic bad_extbus;
   } trap_evt_t;
   typedef struct packed {
      logic        req;
      logic [1:0]  level;
      logic [23:0] vector;
      logic [7:0]  number;
   } trap_out_t;
   typedef struct packed {
      wb_rsp_t     wb;
      logic [15:0] trap_flag_register;
      logic [4:0]  irq_stat;
      logic [4:0]  irq_mask;
      logic        irq;
      logic [4:0]  pend;
      logic [4:0]  grant;
      logic [2:0]  active;
      logic        busy;
      logic [3:0]  ilvl;
      logic [3:0]  svec;
      trap_out_t   trap;
   } main_state_t;
endpackage

/* core/xirq_select_slice.sv */
// one shared vector select register: enable byte and sticky flag byte
`timescale 1ns/1ps
`default_nettype none
`include "xbus_irq_map.svh"
module xirq_select_slice (
   input  wire logic                  clk_sys_i,
   input  wire logic                  srst_i,
   input  wire logic [7:0]            evt_i,
   input  wire logic                  wr_en_i,
   input  wire logic [1:0]            byte_en_i,
   input  wire logic [15:0]           wr_data_i,
   output var  xbus_irq_pkg::sel_reg_t reg_o
);
   xbus_irq_pkg::sel_reg_t r;
   xbus_irq_pkg::sel_reg_t next_r;
   logic [7:0]             clr;

   always_comb begin
      next_r = r;
      clr = 8'h00;
      if (wr_en_i && byte_en_i[1]) begin
         next_r.enable = wr_data_i[15:8];
      end
      // writing zero clears a flag; ones leave it alone
      if (wr_en_i && byte_en_i[0]) begin
         clr = ~wr_data_i[7:0];
      end
      // set wins over clear, and flags set whatever the enable says
      next_r.flag = (r.flag & ~clr) | evt_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         r <= `XIRQ_SEL_RST;
      end else begin
         r <= next_r;
      end
   end

   assign reg_o = r;
endmodule
`default_nettype wire

/* core/trap_prioritizer.sv */
// picks the highest pending trap and gives its vector, number and level
`timescale 1ns/1ps
`default_nettype none
`include "xbus_irq_map.svh"
module trap_prioritizer (
   input  wire logic [4:0]  pend_i,
   output logic      [4:0]  grant_o,
   output logic      [1:0]  level_o,
   output logic      [23:0] vector_o,
   output logic      [7:0]  number_o
);
   // entry order: 0 reset, 1 nmi, 2 stack over, 3 stack under, 4 class b
   always_comb begin
      grant_o = 5'h00;
      level_o = `LVL_NONE;
      vector_o = `VEC_RESET;
      number_o = `NUM_RESET;
      if (pend_i[0]) begin
         grant_o = 5'h01;
         level_o = `LVL_RESET;
      end else if (pend_i[1]) begin
         grant_o = 5'h02;
         level_o = `LVL_CLASS_A;
         vector_o = `VEC_NMI;
         number_o = `NUM_NMI;
      end else if (pend_i[2]) begin
         grant_o = 5'h04;
         level_o = `LVL_CLASS_A;
         vector_o = `VEC_STACK_OVER_FLAG;
         number_o = `NUM_STACK_OVER_FLAG;
      end else if (pend_i[3]) begin
         grant_o = 5'h08;
         level_o = `LVL_CLASS_A;
         vector_o = `VEC_STACK_UNDER_FLAG;
         number_o = `NUM_STACK_UNDER_FLAG;
      end else if (pend_i[4]) begin
         grant_o = 5'h10;
         level_o = `LVL_CLASS_B;
         vector_o = `VEC_CLASS_B;
         number_o = `NUM_CLASS_B;
      end
   end
endmodule
`default_nettype wire

/* core/xbus_irq_mux_and_trap_vectors.sv */
// shared extension interrupt multiplexer and hardware trap vector sequencer
`timescale 1ns/1ps
`default_nettype none
`include "xbus_irq_map.svh"
module xbus_irq_mux_and_trap_vectors (
   input  wire logic                    clk_sys_i,
   input  wire logic                    srst_i,
   input  wire xbus_irq_pkg::wb_req_t   wb_i,
   output var  xbus_irq_pkg::wb_rsp_t   wb_o,
   input  wire xbus_irq_pkg::xsrc_t     src_i,
   input  wire xbus_irq_pkg::trap_evt_t trap_evt_i,
   input  wire logic                    trap_ack_i,
   input  wire logic                    trap_done_i,
   output var  xbus_irq_pkg::trap_out_t trap_o,
   output logic                         trap_active_o,
   output logic [3:0]                   cpu_priority_level_o,
   output logic [3:0]                   shared_vector_o,
   output logic                         irq_o
);
   // =====================================================================
   // declarations
   xbus_irq_pkg::main_state_t r;
   xbus_irq_pkg::main_state_t next_r;
   xbus_irq_pkg::sel_reg_t    sel_q [4];
   logic [7:0]                sel_evt [4];
   logic [3:0]                sel_wr;
   logic [3:0]                sel_req;
   logic                      sel_hit;
   logic                      wr;
   logic                      rd;
   logic                      take;
   logic [15:0]               tfr_set;
   logic [15:0]               tfr_clr;
   logic [4:0]                stat_set;
   logic [4:0]                stat_clr;
   logic [4:0]                pend_set;
   logic [4:0]                pend_clr;
   logic [4:0]                p_grant;
   logic [1:0]                p_level;
   logic [23:0]               p_vector;
   logic [7:0]                p_number;
   logic [1:0]                cur_lvl;
   logic                      lo_wr1;

   function automatic logic [1:0] lvl_of(input logic [2:0] act);
      logic [1:0] l;
      l = `LVL_NONE;
      if (act[2]) begin
         l = `LVL_RESET;
      end else if (act[1]) begin
         l = `LVL_CLASS_A;
      end else if (act[0]) begin
         l = `LVL_CLASS_B;
      end
      return l;
   endfunction

   // =====================================================================
   // bus decode
   assign wr = wb_i.cyc & wb_i.stb & wb_i.we & ~r.wb.ack;
   assign rd = wb_i.cyc & wb_i.stb & ~wb_i.we & ~r.wb.ack;
   assign sel_hit = wr && (wb_i.adr[7:4] == `XIRQ_SEL_BASE);
   assign lo_wr1 = sel_wr[1] & wb_i.sel[0];
   assign cur_lvl = lvl_of(r.active);

   // =====================================================================
   // source routing, slot order fixed per vector
   always_comb begin
      sel_evt[0] = {src_i.async_tbuf, src_i.async_tx, src_i.async_rx, src_i.sync_tx,
                    src_i.sync_rx, src_i.i2c_tx, src_i.i2c_rx,
                    src_i.first_can_controller};
      sel_evt[1] = {src_i.async_tbuf, src_i.async_tx, src_i.async_rx, src_i.sync_tx,
                    src_i.sync_rx, src_i.i2c_tx, src_i.i2c_rx,
                    src_i.second_can_controller};
      sel_evt[2] = {src_i.async_tbuf, src_i.async_tx, src_i.async_rx, src_i.sync_tx,
                    src_i.sync_rx, src_i.i2c_tx, src_i.i2c_rx,
                    src_i.second_pwm_unit};
      // slot 7 of vector 3 has no source and stays zero
      sel_evt[3] = {1'b0, src_i.second_pwm_unit, src_i.pll_unlock, src_i.async_err,
                    src_i.sync_err, src_i.i2c_err, src_i.second_can_controller,
                    src_i.first_can_controller};
   end

   // =====================================================================
   // four select registers
   for (genvar i = 0; i < 4; i++) begin : g_sel
      assign sel_wr[i] = sel_hit && (wb_i.adr[3:2] == 2'(i));
      xirq_select_slice u_slice (
         .clk_sys_i (clk_sys_i),
         .srst_i    (srst_i),
         .evt_i     (sel_evt[i]),
         .wr_en_i   (sel_wr[i]),
         .byte_en_i (wb_i.sel[1:0]),
         .wr_data_i (wb_i.dat[15:0]),
         .reg_o     (sel_q[i])
      );
      // enable masks the flag before the or
      assign sel_req[i] = |(sel_q[i].flag & sel_q[i].enable);
   end

   // =====================================================================
   // trap selection
   trap_prioritizer u_prio (
      .pend_i   (r.pend),
      .grant_o  (p_grant),
      .level_o  (p_level),
      .vector_o (p_vector),
      .number_o (p_number)
   );

   // =====================================================================
   // next state
   always_comb begin
      next_r = r;
      // bus: one wait-free ack, then ack drops for a cycle
      next_r.wb.ack = wb_i.cyc & wb_i.stb & ~r.wb.ack;
      next_r.wb.dat = 32'h0000_0000;
      if (rd) begin
         if (wb_i.adr[7:4] == `XIRQ_SEL_BASE) begin
            next_r.wb.dat = {16'h0000, sel_q[wb_i.adr[3:2]]};
         end else begin
            case (wb_i.adr)
               `XIRQ_TFR_OFS: begin
                  next_r.wb.dat = {16'h0000, r.trap_flag_register};
               end
               `XIRQ_STAT_OFS: begin
                  next_r.wb.dat = {27'h000_0000, r.irq_stat};
               end
               `XIRQ_MASK_OFS: begin
                  next_r.wb.dat = {27'h000_0000, r.irq_mask};
               end
               default: begin
                  next_r.wb.dat = 32'h0000_0000;
               end
            endcase
         end
      end

      // trap flags, one bit per condition except sw_reset and wdt_overflow, write one to clear
      tfr_set = 16'h0000;
      tfr_set[`TFR_NMI] = trap_evt_i.nmi;
      tfr_set[`TFR_STACK_OVER_FLAG] = trap_evt_i.stack_over;
      tfr_set[`TFR_STACK_UNDER_FLAG] = trap_evt_i.stack_under;
      tfr_set[`TFR_UNDOP] = trap_evt_i.undefined_opcode;
      tfr_set[`TFR_MAC] = trap_evt_i.mac_interruption;
      tfr_set[`TFR_PROT] = trap_evt_i.protected_fault;
      tfr_set[`TFR_BADOP] = trap_evt_i.bad_operand;
      tfr_set[`TFR_BADFETCH] = trap_evt_i.bad_fetch;
      tfr_set[`TFR_BADBUS] = trap_evt_i.bad_extbus;
      tfr_clr = 16'h0000;
      if (wr && wb_i.adr == `XIRQ_TFR_OFS) begin
         tfr_clr[7:0] = wb_i.sel[0] ? wb_i.dat[7:0] : 8'h00;
         tfr_clr[15:8] = wb_i.sel[1] ? wb_i.dat[15:8] : 8'h00;
      end
      next_r.trap_flag_register = (r.trap_flag_register & ~tfr_clr) | tfr_set;

      // interrupt status: per vector source events, bit 4 any trap flag set
      stat_set = {|tfr_set, |sel_evt[3], |sel_evt[2], |sel_evt[1], |sel_evt[0]};
      stat_clr = 5'h00;
      if (wr && wb_i.sel[0] && wb_i.adr == `XIRQ_STAT_OFS) begin
         stat_clr = wb_i.dat[4:0];
      end
      next_r.irq_stat = (r.irq_stat & ~stat_clr) | stat_set;
      if (wr && wb_i.sel[0] && wb_i.adr == `XIRQ_MASK_OFS) begin
         next_r.irq_mask = wb_i.dat[4:0];
      end
      next_r.irq = |(next_r.irq_stat & next_r.irq_mask);

      // pending traps; a new event in the take cycle stays pending
      take = trap_ack_i & r.trap.req;
      pend_set = {trap_evt_i.undefined_opcode | trap_evt_i.mac_interruption |
                  trap_evt_i.protected_fault | trap_evt_i.bad_operand |
                  trap_evt_i.bad_fetch | trap_evt_i.bad_extbus,
                  trap_evt_i.stack_under, trap_evt_i.stack_over, trap_evt_i.nmi,
                  trap_evt_i.sw_reset | trap_evt_i.wdt_overflow};
      pend_clr = take ? r.grant : 5'h00;
      next_r.pend = (r.pend & ~pend_clr) | pend_set;

      // nesting: done leaves the innermost service, take enters a new one
      if (trap_done_i) begin
         if (r.active[2]) begin
            next_r.active[2] = 1'b0;
         end else if (r.active[1]) begin
            next_r.active[1] = 1'b0;
         end else begin
            next_r.active[0] = 1'b0;
         end
      end
      if (take) begin
         case (r.trap.level)
            `LVL_RESET: begin
               next_r.active[2] = 1'b1;
            end
            `LVL_CLASS_A: begin
               next_r.active[1] = 1'b1;
            end
            `LVL_CLASS_B: begin
               next_r.active[0] = 1'b1;
            end
            default: begin
               next_r.active = next_r.active;
            end
         endcase
      end
      next_r.busy = |next_r.active;
      next_r.ilvl = next_r.busy ? `ILVL_MAX : `ILVL_NONE;
      // shared vectors are held off while any trap is serviced
      next_r.svec = next_r.busy ? 4'h0 : sel_req;

      // a take drops the request for one cycle so a stale entry is never taken twice
      next_r.grant = take ? 5'h00 : p_grant;
      next_r.trap.req = (p_level > lvl_of(next_r.active)) & ~take;
      next_r.trap.level = p_level;
      next_r.trap.vector = p_vector;
      next_r.trap.number = p_number;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         r <= '0;
         // a hardware reset leaves the reset vector pending
         r.pend <= `XIRQ_PEND_RST;
      end else begin
         r <= next_r;
      end
   end

   // =====================================================================
   // outputs
   assign wb_o = r.wb;
   assign trap_o = r.trap;
   assign trap_active_o = r.busy;
   assign cpu_priority_level_o = r.ilvl;
   assign shared_vector_o = r.svec;
   assign irq_o = r.irq;

   // =====================================================================
   // assertions
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   vec_or_a: assert property (
      shared_vector_o[0] == ($past(sel_req[0]) && !trap_active_o))
      else $error("shared vector 0 not the masked or of its flags");
   vec_mask_a: assert property (
      shared_vector_o[3] |-> $past(sel_q[3].enable[5]) || !$past(sel_q[3].flag[5]) ||
      $past(sel_req[3]))
      else $error("shared vector 3 raised without an enabled flag");
   flag_poll_a: assert property (
      (src_i.first_can_controller && !sel_q[0].enable[0]) |=> sel_q[0].flag[0])
      else $error("masked source event did not set its flag");
   flag_hold_a: assert property (
      ($past(sel_q[1].flag[2]) && !$past(lo_wr1)) |-> sel_q[1].flag[2])
      else $error("flag dropped without a select write");
   route_data_a: assert property (
      src_i.async_tbuf |=> sel_q[0].flag[7] && sel_q[1].flag[7] && sel_q[2].flag[7]
      && !sel_q[3].flag[7])
      else $error("transmit buffer event routed wrongly");
   route_err_a: assert property (
      src_i.pll_unlock |=> sel_q[3].flag[5])
      else $error("pll unlock did not reach vector 3");
   reset_vec_a: assert property (
      (trap_o.req && trap_o.level == `LVL_RESET) |->
      (trap_o.vector == `VEC_RESET && trap_o.number == `NUM_RESET))
      else $error("reset vector or number wrong");
   nmi_vec_a: assert property (
      (trap_o.req && trap_o.vector == `VEC_NMI) |->
      (trap_o.number == `NUM_NMI && trap_o.level == `LVL_CLASS_A))
      else $error("nmi trap number or level wrong");
   classb_vec_a: assert property (
      (trap_o.req && trap_o.level == `LVL_CLASS_B) |->
      (trap_o.vector == `VEC_CLASS_B && trap_o.number == `NUM_CLASS_B))
      else $error("class b vector or number wrong");
   bad_bus_a: assert property (
      trap_evt_i.bad_extbus |=> r.trap_flag_register[`TFR_BADBUS] && r.pend[4])
      else $error("bus access fault not flagged");
   tfr_flag_a: assert property (
      trap_evt_i.stack_over |=> r.trap_flag_register[`TFR_STACK_OVER_FLAG])
      else $error("stack overflow flag not set");
   ilvl_force_a: assert property (
      trap_active_o |-> cpu_priority_level_o == `ILVL_MAX)
      else $error("cpu priority level not forced during trap service");
   trap_block_a: assert property (
      trap_active_o |-> shared_vector_o == 4'h0)
      else $error("shared vector raised during trap service");
   preempt_a: assert property (
      trap_o.req |-> trap_o.level > cur_lvl)
      else $error("trap request not above the level in service");
   ack_once_a: assert property (
      wb_o.ack |=> !wb_o.ack)
      else $error("bus ack held for two cycles");
endmodule
`default_nettype wire

/* sim/cpu_trap_model.sv */
// cpu exception sequencer model: takes a presented trap after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module cpu_trap_model (
   input  wire logic       clk_sys_i,
   input  wire logic       srst_i,
   input  wire logic       req_i,
   input  wire logic [1:0] delay_i,
   output logic            ack_o
);
   // =====================================================================
   // take logic
   logic [1:0] wait_cnt;

   // ack only while a request stands, one pulse, so a slow cpu is modelled too
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !req_i || ack_o) begin
         wait_cnt <= 2'h0;
         ack_o    <= 1'b0;
      end else if (wait_cnt == delay_i) begin
         ack_o <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule
`default_nettype wire

/* sim/xbus_irq_mux_and_trap_vectors_test.sv */
// self-checking bench for the shared interrupt multiplexer and trap vectors
`timescale 1ns/1ps
`default_nettype none
module xbus_irq_mux_and_trap_vectors_test;
   // =====================================================================
   // stimulus and observed signals
   logic                    clk_sys_i = 1'b0;
   logic                    srst_i = 1'b1;
   xbus_irq_pkg::wb_req_t   wb_i = '0;
   xbus_irq_pkg::wb_rsp_t   wb_o;
   xbus_irq_pkg::xsrc_t     src_i = '0;
   xbus_irq_pkg::trap_evt_t trap_evt_i = '0;
   logic                    trap_ack_i;
   logic                    trap_done_i = 1'b0;
   xbus_irq_pkg::trap_out_t trap_o;
   logic                    trap_active_o;
   logic [3:0]              cpu_priority_level_o;
   logic [3:0]              shared_vector_o;
   logic                    irq_o;
   logic [1:0]              ack_delay = 2'h0;
   logic [31:0]             rdata;
   int                      err_total = 0;
   int                      checks_done = 0;
   int                      tpos [9] = '{0, 1, 2, 3, 6, 7, 13, 14, 15};
   // flag bytes {v3,v2,v1,v0} per source bit, lowest bit first
   logic [31:0]             route [14] = '{32'h4001_0000, 32'h2000_0000, 32'h1000_0000,
      32'h0080_8080, 32'h0040_4040, 32'h0020_2020, 32'h0800_0000, 32'h0010_1010,
      32'h0008_0808, 32'h0400_0000, 32'h0004_0404, 32'h0002_0202, 32'h0200_0100,
      32'h0100_0001};

   initial forever #10 clk_sys_i = ~clk_sys_i;

   xbus_irq_mux_and_trap_vectors u_xbus_irq_mux_and_trap_vectors (.clk_sys_i, .srst_i, .wb_i,
      .wb_o, .src_i, .trap_evt_i, .trap_ack_i, .trap_done_i, .trap_o, .trap_active_o,
      .cpu_priority_level_o, .shared_vector_o, .irq_o);
   cpu_trap_model u_cpu_trap_model (.clk_sys_i, .srst_i, .req_i(trap_o.req),
      .delay_i(ack_delay), .ack_o(trap_ack_i));

   // =====================================================================
   // tasks
   task automatic finish_test();
      if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tmo();
      err_total++;
      finish_test();
   endtask
   task automatic chk(input logic [34:0] got, input logic [34:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // entered just after a rising edge; the answer time is never assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      wb_i <= {2'b11, w, a, s, 16'h0000, d};
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wb_o.ack !== 1'b1 && n < 16);
      if (wb_o.ack !== 1'b1) tmo();
      rdata = wb_o.dat;
      wb_i <= '0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
      bus(1'b1, a, d, s);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 16'h0000, 4'b0011);
      chk(rdata, e);
   endtask
   task automatic evt(input logic [13:0] s, input logic [10:0] t);
      src_i <= s;
      trap_evt_i <= t;
      @(posedge clk_sys_i);
      src_i <= '0;
      trap_evt_i <= '0;
      @(posedge clk_sys_i);
   endtask
   task automatic wait_hi(input logic act);
      int n;
      n = 0;
      while ((act ? trap_active_o : trap_o.req) !== 1'b1) begin
         @(posedge clk_sys_i);
         n++;
         if (n > 30) tmo();
      end
   endtask
   task automatic serve(input logic [34:0] exp);
      wait_hi(1'b0);
      chk(trap_o, exp);
      wait_hi(1'b1);
      chk({cpu_priority_level_o, shared_vector_o}, 8'hF0);
      trap_done_i <= 1'b1;
      @(posedge clk_sys_i);
      trap_done_i <= 1'b0;
      @(posedge clk_sys_i);
      chk({trap_active_o, cpu_priority_level_o}, 5'h00);
   endtask

   // =====================================================================
   // main sequence
   initial begin
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      serve({3'b111, 32'h0000_0000});
      for (int i = 0; i < 11; i++) begin
         ack_delay <= 2'(i);
         evt('0, 11'h001 << i);
         serve(i > 8 ? {3'b111, 32'h0000_0000} : i > 5 ?
            {3'b110, 24'(8 * (9 - i)), 8'(2 * (9 - i))} : {3'b101, 24'h00_0028, 8'h0A});
         if (i < 9) begin
            rd(8'h10, 16'h0001 << tpos[i]);
            wr(8'h10, 16'hFFFF, 4'b0011);
         end
      end
      for (int v = 0; v < 4; v++) rd(8'(4 * v), 32'h0000_0000);
      evt(14'h2000, '0);
      @(posedge clk_sys_i);
      chk(shared_vector_o, 4'h0);
      rd(8'h00, 32'h0000_0001);
      rd(8'h0C, 32'h0000_0001);
      wr(8'h00, 16'hFF00, 4'b0010);
      @(posedge clk_sys_i);
      chk(shared_vector_o, 4'h1);
      for (int i = 0; i < 14; i++) begin
         for (int v = 0; v < 4; v++) wr(8'(4 * v), 16'hFF00, 4'b0011);
         evt(14'h0001 << i, '0);
         @(posedge clk_sys_i);
         chk(shared_vector_o, {|route[i][31:24], |route[i][23:16], |route[i][15:8],
            |route[i][7:0]});
         for (int v = 0; v < 4; v++) rd(8'(4 * v), {16'h0000, 8'hFF, route[i][8*v+:8]});
      end
      // interrupt status, mask, clear and unmapped place
      wr(8'h18, 16'h0001, 4'b0011);
      wr(8'h14, 16'h001F, 4'b0011);
      evt(14'h2000, '0);
      chk(irq_o, 1'b1);
      rd(8'h14, 32'h0000_0009);
      rd(8'h18, 32'h0000_0001);
      wr(8'h14, 16'h0001, 4'b0011);
      @(posedge clk_sys_i);
      chk(irq_o, 1'b0);
      rd(8'h40, 32'h0000_0000);
      wr(8'h40, 16'hFFFF, 4'b0011);
      // class a and class b raised together
      evt('0, 11'h120);
      serve({3'b110, 24'h00_0008, 8'h02});
      serve({3'b101, 24'h00_0028, 8'h0A});
      repeat (2) @(posedge clk_sys_i);
      chk(shared_vector_o, 4'h9);
      finish_test();
   end
endmodule
`default_nettype wire
